// ---- hw/fgc_pkg.sv ----
// shared constants and types of the four-channel gated counter
package fgc_pkg;
   localparam int          NUM_CH       = 4;
   localparam int          CNT_W        = 32;
   localparam int          ADDR_W       = 10;
   localparam int          NUM_EV       = 6;
   // input byte addresses of the channel count values
   localparam logic [9:0]  ADDR_CH0     = 10'h330;
   localparam logic [9:0]  ADDR_CH1     = 10'h334;
   localparam logic [9:0]  ADDR_CH2     = 10'h338;
   localparam logic [9:0]  ADDR_CH3     = 10'h33c;
   // reset values, and the signed extremes of the count
   localparam logic [31:0] LIMIT_RST    = 32'h7fffffff;
   localparam logic [31:0] CMP_RST      = 32'h00000000;
   localparam logic [7:0]  HYST_RST     = 8'h00;
   localparam logic [31:0] COUNT_RST    = 32'h00000000;
   localparam logic [31:0] SMAX         = 32'h7fffffff;
   localparam logic [31:0] SMIN         = 32'h80000000;
   // event bit positions in the event enable and event vectors
   localparam int          EV_GATE_OPEN = 0;
   localparam int          EV_GATE_CLOS = 1;
   localparam int          EV_CMP       = 2;
   localparam int          EV_PULSE     = 3;
   localparam int          EV_OVER      = 4;
   localparam int          EV_UNDER     = 5;
   typedef enum logic [1:0] {
      FGC_DIR_NONE = 2'h0,
      FGC_DIR_UP   = 2'h1,
      FGC_DIR_DOWN = 2'h3
   } fgc_dir_t;
   typedef enum logic [1:0] {
      FGC_EVAL_PDIR = 2'h0,
      FGC_EVAL_X1   = 2'h1,
      FGC_EVAL_X2   = 2'h3,
      FGC_EVAL_X4   = 2'h2
   } fgc_eval_t;
   typedef enum logic [1:0] {
      FGC_IRQ_NONE = 2'h0,
      FGC_IRQ_PROC = 2'h1,
      FGC_IRQ_DIAG = 2'h3
   } fgc_irq_t;
endpackage

// ---- hw/fgc_counter.sv ----
// four-channel gated 32-bit pulse and encoder counter
`timescale 1ns/1ps
// Summary of operation
// - count values readable at 0x330..0x33c
// - no main direction: unrestricted counting
// - up: wrap from end minus one
// - down: wrap below one to start
// - start/end limit up to 2^31-1
// - cancel mode: each opening reloads load value
// - stop mode: hold count while gate closed
// - compare count against signed comparison value
// - hysteresis 0..255, 0 and 1 disable
// - pulse/direction evaluation is default
// - encoder single, double or quadruple evaluation
// - hardware gate enabled: channel 3 both gates
// - hardware gate disabled: software gate only
// - optional per-channel direction inversion
// - interrupt selection none: no interrupts
// - process mode: interrupt per selected event
// - diagnostic interrupt only on lost interrupt
// - hardware gate pin high opens gate, low closes it
// - latch rising edge captures channel 3 count
module fgc_counter (
   input  wire logic                          clock_i,
   input  wire logic                          srst_i,
   input  wire logic [3:0]                    track_a_i,
   input  wire logic [3:0]                    track_b_i,
   input  wire logic                          gate3_i,
   input  wire logic                          latch3_i,
   input  wire logic [3:0]                    software_gate_i,
   input  wire logic                          hardware_gate_en_i,
   input  wire fgc_pkg::fgc_dir_t             main_dir_i [4],
   input  wire fgc_pkg::fgc_eval_t            eval_mode_i [4],
   input  wire logic [3:0]                    gate_stop_mode_i,
   input  wire logic [3:0]                    continuous_i,
   input  wire logic [3:0]                    dir_invert_i,
   input  wire logic [31:0]                   load_value_i [4],
   input  wire logic [31:0]                   limit_value_i [4],
   input  wire logic [31:0]                   cmp_value_i [4],
   input  wire logic [7:0]                    hysteresis_i [4],
   input  wire fgc_pkg::fgc_irq_t             irq_select_i,
   input  wire logic [5:0]                    event_en_i [4],
   input  wire logic [3:0]                    irq_ack_i,
   input  wire logic                          diag_ack_i,
   input  wire logic [fgc_pkg::ADDR_W-1:0]    rd_addr_i,
   output logic      [31:0]                   rd_data_o,
   output logic      [31:0]                   latch_value_o,
   output logic      [3:0]                    cmp_o,
   output logic      [3:0]                    hw_irq_o,
   output logic                               diag_irq_o
);
   import fgc_pkg::*;

   // returns {step, up}; up means track a leads track b, or track b is low in pulse/direction mode
   function automatic logic [1:0] decode(input fgc_eval_t m,
                                         input logic a, input logic b,
                                         input logic pa, input logic pb);
      logic ea;
      logic eb;
      ea = a ^ pa;
      eb = b ^ pb;
      unique case (m)
         FGC_EVAL_PDIR: decode = {a & ~pa, ~b};
         FGC_EVAL_X1:   decode = {a & ~pa, ~b};
         FGC_EVAL_X2:   decode = {ea, a ^ b};
         FGC_EVAL_X4:   decode = {ea | eb, ea ? (a ^ b) : ~(a ^ b)};
      endcase
   endfunction

   logic [3:0]        a_q;
   logic [3:0]        b_q;
   logic              gate3_q;
   logic              latch3_q;
   logic [3:0]        gate_open;
   logic [3:0]        gate_open_q;
   logic [3:0]        step;
   logic [3:0]        up;
   logic [31:0]       count_reg [4];
   logic [3:0]        over_ev;
   logic [3:0]        under_ev;
   logic [3:0]        cmp_q;
   logic [5:0]        ev [4];
   logic [3:0]        ev_any;
   logic [3:0]        lost;

   // previous track and pin levels for edge detection
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         a_q      <= 4'h0;
         b_q      <= 4'h0;
         gate3_q  <= 1'b0;
         latch3_q <= 1'b0;
      end else begin
         a_q      <= track_a_i;
         b_q      <= track_b_i;
         gate3_q  <= gate3_i;
         latch3_q <= latch3_i;
      end
   end

   // gate level; the hardware gate follows the registered level of its pin, open while high
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         gate_open[i] = software_gate_i[i];
      end
      if (hardware_gate_en_i) begin
         gate_open[3] = software_gate_i[3] & gate3_q;
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         gate_open_q <= 4'h0;
      end else begin
         gate_open_q <= gate_open;
      end
   end

   // edge decode per channel, direction inverted on request
   always_comb begin
      logic [1:0] d;
      d = 2'h0;
      for (int i = 0; i < NUM_CH; i++) begin
         d       = decode(eval_mode_i[i], track_a_i[i], track_b_i[i],
                          a_q[i], b_q[i]);
         step[i] = d[1];
         up[i]   = d[0] ^ dir_invert_i[i];
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         logic        open_edge;
         logic        is_max;
         logic        is_min;
         logic        at_end;
         logic        at_one;
         logic        dn_lim;
         logic signed [32:0] lo_thr;
         logic [31:0] end_m1;
         assign open_edge = gate_open[g] & ~gate_open_q[g];
         assign end_m1    = limit_value_i[g] - 32'h00000001;
         assign is_max    = (count_reg[g] == SMAX);
         assign is_min    = (count_reg[g] == SMIN);
         assign at_end    = $signed(count_reg[g]) >= $signed(end_m1);
         assign at_one    = $signed(count_reg[g]) <= $signed(32'h00000001);
         // continuous counting lifts the downward restriction
         assign dn_lim    = (main_dir_i[g] == FGC_DIR_DOWN) & ~continuous_i[g];

         // count register; opening in cancel mode reloads, closed gate holds
         always_ff @(posedge clock_i) begin
            if (srst_i) begin
               count_reg[g] <= COUNT_RST;
               over_ev[g]   <= 1'b0;
               under_ev[g]  <= 1'b0;
            end else begin
               over_ev[g]  <= 1'b0;
               under_ev[g] <= 1'b0;
               if (open_edge && !gate_stop_mode_i[g]) begin
                  count_reg[g] <= load_value_i[g];
               end else if (gate_open[g] && step[g]) begin
                  if (up[g]) begin
                     if (main_dir_i[g] == FGC_DIR_UP && at_end) begin
                        count_reg[g] <= load_value_i[g];
                        over_ev[g]   <= 1'b1;
                     end else begin
                        count_reg[g] <= count_reg[g] + 32'h00000001;
                        over_ev[g]   <= is_max;
                     end
                  end else begin
                     if (dn_lim && at_one) begin
                        count_reg[g] <= limit_value_i[g];
                        under_ev[g]  <= 1'b1;
                     end else begin
                        count_reg[g] <= count_reg[g] - 32'h00000001;
                        under_ev[g]  <= is_min;
                     end
                  end
               end
            end
         end

         // compare with hysteresis band below the comparison value
         assign lo_thr = $signed({cmp_value_i[g][31], cmp_value_i[g]})
                       - $signed({25'h0, (hysteresis_i[g] > 8'h01)
                                  ? hysteresis_i[g] : 8'h00});
         always_ff @(posedge clock_i) begin
            if (srst_i) begin
               cmp_q[g] <= 1'b0;
            end else if ($signed(count_reg[g]) >= $signed(cmp_value_i[g])) begin
               cmp_q[g] <= 1'b1;
            end else if ($signed({count_reg[g][31], count_reg[g]}) < lo_thr) begin
               cmp_q[g] <= 1'b0;
            end
         end

         // raw events of this channel
         always_comb begin
            ev[g]               = 6'h00;
            ev[g][EV_GATE_OPEN] = open_edge;
            ev[g][EV_GATE_CLOS] = ~gate_open[g] & gate_open_q[g];
            ev[g][EV_CMP]       = cmp_q[g] & ~cmp_o[g];
            ev[g][EV_PULSE]     = gate_open[g] & step[g];
            ev[g][EV_OVER]      = over_ev[g];
            ev[g][EV_UNDER]     = under_ev[g];
         end
         assign ev_any[g] = (irq_select_i != FGC_IRQ_NONE)
                          & |(ev[g] & event_en_i[g]);
         assign lost[g]   = ev_any[g] & hw_irq_o[g];

         // pending interrupt; a new event beats a same-cycle ack
         always_ff @(posedge clock_i) begin
            if (srst_i) begin
               hw_irq_o[g] <= 1'b0;
            end else if (ev_any[g]) begin
               hw_irq_o[g] <= 1'b1;
            end else if (irq_ack_i[g]) begin
               hw_irq_o[g] <= 1'b0;
            end
         end

         a_up_wrap: assert property (@(posedge clock_i) disable iff (srst_i)
            (main_dir_i[g] == FGC_DIR_UP && gate_open[g] && !open_edge
             && step[g] && up[g] && at_end)
            |=> count_reg[g] == $past(load_value_i[g]))
            else $error("up count did not wrap to load value");
         a_down_wrap: assert property (@(posedge clock_i) disable iff (srst_i)
            (dn_lim && gate_open[g] && !open_edge && step[g] && !up[g]
             && at_one) |=> count_reg[g] == $past(limit_value_i[g]))
            else $error("down count did not wrap to start value");
         a_cancel_load: assert property (@(posedge clock_i) disable iff (srst_i)
            (open_edge && !gate_stop_mode_i[g])
            |=> count_reg[g] == $past(load_value_i[g]))
            else $error("gate opening did not reload count");
         a_stop_hold: assert property (@(posedge clock_i) disable iff (srst_i)
            !gate_open[g] |=> $stable(count_reg[g]))
            else $error("count moved while gate closed");
         a_cmp_reach: assert property (@(posedge clock_i) disable iff (srst_i)
            ($signed(count_reg[g]) >= $signed(cmp_value_i[g]))
            |=> ##1 cmp_o[g])
            else $error("comparator not set at comparison value");
         a_irq_none: assert property (@(posedge clock_i) disable iff (srst_i)
            (irq_select_i == FGC_IRQ_NONE && !hw_irq_o[g]) |=> !hw_irq_o[g])
            else $error("interrupt raised with selection none");
      end
   endgenerate

   // comparator outputs are registered copies one cycle behind
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         cmp_o <= 4'h0;
      end else begin
         cmp_o <= cmp_q;
      end
   end

   // diagnostic flag, sticky until acknowledged; set wins over ack
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         diag_irq_o <= 1'b0;
      end else if (irq_select_i == FGC_IRQ_DIAG && |lost) begin
         diag_irq_o <= 1'b1;
      end else if (diag_ack_i) begin
         diag_irq_o <= 1'b0;
      end
   end

   // latch pin rising edge snapshots channel 3
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         latch_value_o <= COUNT_RST;
      end else if (latch3_i && !latch3_q) begin
         latch_value_o <= count_reg[3];
      end
   end

   // input address read; anything else reads zero
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         rd_data_o <= 32'h00000000;
      end else begin
         unique case (rd_addr_i)
            ADDR_CH0: rd_data_o <= count_reg[0];
            ADDR_CH1: rd_data_o <= count_reg[1];
            ADDR_CH2: rd_data_o <= count_reg[2];
            ADDR_CH3: rd_data_o <= count_reg[3];
            default:  rd_data_o <= 32'h00000000;
         endcase
      end
   end

   a_read_ch3: assert property (@(posedge clock_i) disable iff (srst_i)
      (rd_addr_i == ADDR_CH3) |=> rd_data_o == $past(count_reg[3]))
      else $error("channel 3 read returned wrong value");
   a_latch_cap: assert property (@(posedge clock_i) disable iff (srst_i)
      $rose(latch3_i) |=> latch_value_o == $past(count_reg[3]))
      else $error("latch edge did not capture count");
   a_hardware_gate: assert property (@(posedge clock_i) disable iff (srst_i)
      (hardware_gate_en_i && !gate3_q) |-> !gate_open[3])
      else $error("channel 3 open with hardware gate low");
   a_diag_lost: assert property (@(posedge clock_i) disable iff (srst_i)
      (irq_select_i == FGC_IRQ_DIAG && |lost) |=> diag_irq_o)
      else $error("lost interrupt not flagged");
   a_diag_only: assert property (@(posedge clock_i) disable iff (srst_i)
      (!diag_irq_o && !(irq_select_i == FGC_IRQ_DIAG && |lost)) |=> !diag_irq_o)
      else $error("diagnostic flag without lost interrupt");
endmodule

// ---- tb/fgc_enc_model.sv ----
// pulse/direction and two-track encoder source for the count inputs
`timescale 1ns/1ps
module fgc_enc_model (
   input  wire logic       clock_i,
   output logic      [3:0] track_a_o,
   output logic      [3:0] track_b_o
);
   // forward order 00,10,11,01: track a leads track b
   localparam logic [1:0] GRAY [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
   logic [1:0] phase [4];

   initial begin
      track_a_o = 4'h0;
      track_b_o = 4'h0;
      for (int i = 0; i < 4; i++) phase[i] = 2'h0;
   end

   // direction settles a cycle ahead of the count edge, like a real
   // sensor with setup time; pulses are three cycles wide
   task automatic pulse(input int ch, input logic dir_b);
      @(posedge clock_i) track_b_o[ch] <= dir_b;
      @(posedge clock_i) track_a_o[ch] <= 1'b1;
      repeat (3) @(posedge clock_i);
      track_a_o[ch] <= 1'b0;
      repeat (3) @(posedge clock_i);
   endtask

   // one quarter cycle of the encoder, forward or backward
   task automatic quad(input int ch, input logic fwd);
      @(posedge clock_i);
      phase[ch] = fwd ? phase[ch] + 2'h1 : phase[ch] - 2'h1;
      {track_a_o[ch], track_b_o[ch]} <= GRAY[phase[ch]];
      repeat (3) @(posedge clock_i);
   endtask
endmodule

// ---- tb/tb_fgc_counter.sv ----
// self-checking bench of the four-channel gated counter
`timescale 1ns/1ps
module tb_fgc_counter;
   import fgc_pkg::*;
   logic        clock_i, srst_i, gate3, latch3, hw_en, diag_ack;
   logic        diag_irq;
   logic [3:0]  trk_a, trk_b, software_gate, stop_m, contin, inv, ack;
   logic [3:0]  cmp, hw_irq;
   fgc_dir_t    mdir [4];
   fgc_eval_t   eval [4];
   fgc_irq_t    irq_sel;
   logic [31:0] load_v [4], lim_v [4], cmp_v [4];
   logic [7:0]  hyst [4];
   logic [5:0]  ev_en [4];
   logic [9:0]  rd_addr;
   logic [31:0] rd_data, latch_v, d;
   int          num_errors, num_checks;

   fgc_enc_model i_fgc_enc_model (.clock_i(clock_i), .track_a_o(trk_a),
      .track_b_o(trk_b));

   fgc_counter i_fgc_counter (.clock_i(clock_i), .srst_i(srst_i),
      .track_a_i(trk_a), .track_b_i(trk_b), .gate3_i(gate3),
      .latch3_i(latch3), .software_gate_i(software_gate),
      .hardware_gate_en_i(hw_en), .main_dir_i(mdir), .eval_mode_i(eval),
      .gate_stop_mode_i(stop_m), .continuous_i(contin),
      .dir_invert_i(inv), .load_value_i(load_v), .limit_value_i(lim_v),
      .cmp_value_i(cmp_v), .hysteresis_i(hyst), .irq_select_i(irq_sel),
      .event_en_i(ev_en), .irq_ack_i(ack), .diag_ack_i(diag_ack),
      .rd_addr_i(rd_addr), .rd_data_o(rd_data), .latch_value_o(latch_v),
      .cmp_o(cmp), .hw_irq_o(hw_irq), .diag_irq_o(diag_irq));

   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end

   task automatic chk_word(input string nm, input logic [31:0] e,
                           input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic chk_bits(input string nm, input logic [3:0] e,
                           input logic [3:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask

   // read data stands from the edge that takes the address;
   // it is picked up at the following edge, before it moves on
   task automatic rd(input logic [9:0] a, output logic [31:0] q);
      @(posedge clock_i) rd_addr <= a;
      repeat (2) @(posedge clock_i);
      q = rd_data;
   endtask

   task automatic expect_count(input int ch, input logic [31:0] e);
      logic [31:0] q;
      rd(ADDR_CH0 + 10'(4 * ch), q);
      chk_word("count", e, q);
   endtask

   // close and reopen one software gate
   task automatic regate(input int ch);
      @(posedge clock_i) software_gate[ch] <= 1'b0;
      repeat (3) @(posedge clock_i);
      software_gate[ch] <= 1'b1;
      repeat (3) @(posedge clock_i);
   endtask

   task automatic print_verdict();
      if (num_errors == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // a hang costs a mismatch; the run needs well under 20 us
   initial begin
      #100000;
      num_errors++;
      print_verdict();
   end

   initial begin
      srst_i = 1'b1;
      {gate3, latch3, hw_en, diag_ack} = 4'h0;
      {software_gate, stop_m, contin, inv, ack} = 20'h0;
      irq_sel = FGC_IRQ_NONE;
      rd_addr = 10'h0;
      for (int i = 0; i < 4; i++) begin
         mdir[i] = FGC_DIR_NONE;
         eval[i] = FGC_EVAL_PDIR;
         load_v[i] = 32'h0;
         lim_v[i] = LIMIT_RST;
         cmp_v[i] = CMP_RST;
         hyst[i] = HYST_RST;
         ev_en[i] = 6'h00;
      end
      mdir[1] = FGC_DIR_UP;
      lim_v[1] = 32'h2;
      ev_en[1] = 6'h10;
      mdir[2] = FGC_DIR_DOWN;
      lim_v[2] = 32'h3;
      ev_en[2] = 6'h20;
      eval[3] = FGC_EVAL_X4;
      cmp_v[0] = 32'h2;
      hyst[0] = 8'h01;
      repeat (8) @(posedge clock_i);
      srst_i <= 1'b0;
      for (int c = 0; c < 4; c++) expect_count(c, 32'h0);
      rd(10'h340, d);
      chk_word("unmapped", 32'h0, d);
      software_gate <= 4'hf;
      repeat (4) @(posedge clock_i);
      // channel 0: free range, inversion, compare with hysteresis 1
      i_fgc_enc_model.pulse(0, 1'b1);
      expect_count(0, 32'hffffffff);
      repeat (3) i_fgc_enc_model.pulse(0, 1'b0);
      chk_bits("cmp0", 4'h1, {3'h0, cmp[0]});
      inv[0] <= 1'b1;
      i_fgc_enc_model.pulse(0, 1'b0);
      expect_count(0, 32'h1);
      chk_bits("cmp0", 4'h0, {3'h0, cmp[0]});
      load_v[0] <= 32'h0000000a;
      regate(0);
      expect_count(0, 32'h0000000a);
      // stop mode: a pulse while closed is lost, count is kept
      stop_m[0] <= 1'b1;
      @(posedge clock_i) software_gate[0] <= 1'b0;
      i_fgc_enc_model.pulse(0, 1'b1);
      software_gate[0] <= 1'b1;
      repeat (3) @(posedge clock_i);
      i_fgc_enc_model.pulse(0, 1'b1);
      expect_count(0, 32'h0000000b);
      // a band of two keeps the comparator set just below its value
      cmp_v[0] <= 32'h0000000c;
      hyst[0] <= 8'h02;
      repeat (3) @(posedge clock_i);
      chk_bits("cmp0", 4'h1, {3'h0, cmp[0]});
      // channel 1: up range of two, overflow interrupts
      repeat (2) i_fgc_enc_model.pulse(1, 1'b0);
      expect_count(1, 32'h0);
      chk_bits("irq", 4'h0, hw_irq);
      irq_sel <= FGC_IRQ_PROC;
      i_fgc_enc_model.pulse(1, 1'b0);
      expect_count(1, 32'h1);
      i_fgc_enc_model.pulse(1, 1'b0);
      chk_bits("irq", 4'h2, hw_irq);
      repeat (2) i_fgc_enc_model.pulse(1, 1'b0);
      chk_bits("diag", 4'h0, {3'h0, diag_irq});
      irq_sel <= FGC_IRQ_DIAG;
      repeat (2) i_fgc_enc_model.pulse(1, 1'b0);
      chk_bits("diag", 4'h1, {3'h0, diag_irq});
      @(posedge clock_i) {ack, diag_ack} <= 5'h05;
      @(posedge clock_i) {ack, diag_ack} <= 5'h00;
      @(posedge clock_i) #1 chk_bits("ack", 4'h0, hw_irq | diag_irq);
      // channel 2: down range from three, then continuous
      repeat (3) i_fgc_enc_model.pulse(2, 1'b1);
      expect_count(2, 32'h1);
      i_fgc_enc_model.pulse(2, 1'b1);
      expect_count(2, 32'h3);
      contin[2] <= 1'b1;
      repeat (3) i_fgc_enc_model.pulse(2, 1'b1);
      expect_count(2, 32'h0);
      chk_bits("irq", 4'h4, hw_irq);
      // channel 3: hardware gate, encoder modes, latch
      hw_en <= 1'b1;
      repeat (3) @(posedge clock_i);
      repeat (4) i_fgc_enc_model.quad(3, 1'b1);
      expect_count(3, 32'h0);
      gate3 <= 1'b1;
      repeat (4) @(posedge clock_i);
      repeat (4) i_fgc_enc_model.quad(3, 1'b1);
      expect_count(3, 32'h4);
      i_fgc_enc_model.quad(3, 1'b0);
      expect_count(3, 32'h3);
      i_fgc_enc_model.quad(3, 1'b1);
      eval[3] <= FGC_EVAL_X1;
      repeat (4) i_fgc_enc_model.quad(3, 1'b1);
      expect_count(3, 32'h5);
      eval[3] <= FGC_EVAL_X2;
      repeat (4) i_fgc_enc_model.quad(3, 1'b1);
      expect_count(3, 32'h7);
      @(posedge clock_i) latch3 <= 1'b1;
      repeat (3) @(posedge clock_i);
      latch3 <= 1'b0;
      #1 chk_word("latch", 32'h7, latch_v);
      @(posedge clock_i) hw_en <= 1'b0;
      @(posedge clock_i) gate3 <= 1'b0;
      repeat (4) i_fgc_enc_model.quad(3, 1'b1);
      expect_count(3, 32'h9);
      chk_word("latch", 32'h7, latch_v);
      print_verdict();
   end
endmodule
